// ---- src/bpc_pkg.sv ----
// constants, types and rule overview for the motor pre-driver control block
// Overview of operation
// - ignore current trip for 1.5 us blanking
// - blanking starts when fixed off-time ends
// - enable chop or direction change restarts blanking
// - external PWM: direction change, enable-on start blanking
// - PWM-off turns on recirculation transistors
// - brake request low turns on all low sides
// - brake overrides enable and lock detection
// - enable high over 3 ms enters standby
// - no standby while brake is requested
// - pump rail fault disables all gates
// - thermal, pump, supply faults hold gates off
// - overvoltage suppresses synchronous rectification
// - thermal trip at 170C, release after hysteresis
// - first tach toggles on any hall edge
// - second tach toggles on phase-A hall edge
// - lock on stalled tach or broken sequence
// - lock must persist 127 oscillator periods
// - lock wait expiry disables gates, latches fault
// - lock clears: direction edge, UVLO release, enable
// - grounded lock capacitor disables lock detection
// - brake holds lock counter at zero
// - current trip clears high side, starts off-time
// - fixed off-time is 25 us
// - enable low drives pair, high chops high side
package bpc_pkg;
	localparam int CLK_FREQ_MHZ         = 200;
	localparam int BLANK_TIME_NS        = 1500;
	localparam int BLANK_CYCLES         = (BLANK_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int OFF_TIME_NS          = 25000;
	localparam int OFF_TIME_CYCLES      = (OFF_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int STANDBY_TIME_NS      = 3000000;
	localparam int STANDBY_TIME_CYCLES  = (STANDBY_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int LOCK_WAIT_PERIODS    = 127;
	// synchroniser lanes
	localparam int IN_W                 = 6;
	localparam int IN_HALL_A            = 0;
	localparam int IN_HALL_C            = 2;
	localparam int IN_ENABLE_N          = 3;
	localparam int IN_DIR               = 4;
	localparam int IN_BRAKE_N           = 5;
	localparam logic [5:0] IN_RST_VAL   = 6'h28;
	// register map, byte addresses
	localparam logic [3:0] REG_CTRL     = 4'h0;
	localparam logic [3:0] REG_STATUS   = 4'h4;
	localparam logic [31:0] CTRL_RST    = 32'h0000_0003;
	localparam int CTRL_LOCK_EN         = 0;
	localparam int CTRL_SYNC_RECT_EN    = 1;
	localparam int ST_STANDBY           = 0;
	localparam int ST_LOCK_FAULT        = 1;
	localparam int ST_THERMAL           = 2;
	localparam int ST_BRAKE             = 3;
	localparam int ST_HARD_FAULT        = 4;
	localparam int ST_OVERVOLT          = 5;
	localparam int ST_TACH1_PIN         = 6;
	localparam int ST_TACH2_PIN         = 7;
	typedef enum logic [1:0] {
		BPC_DRIVE = 2'b00,
		BPC_OFF   = 2'b01,
		BPC_BLANK = 2'b10
	} bpc_state_t;
endpackage

// ---- src/bpc_input_sync.sv ----
// two-flop synchroniser with edge detection for a vector of pins
`timescale 1ns/10ps
`default_nettype none
module bpc_input_sync #(
	parameter int               WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
)(
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	// raw pins
	input  wire logic [WIDTH-1:0] i_pin,
	// synchronised level and edges
	output logic      [WIDTH-1:0] o_level,
	output logic      [WIDTH-1:0] o_rise,
	output logic      [WIDTH-1:0] o_fall
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;
	logic [WIDTH-1:0] prev_r;

	// meta_r feeds sync_r only
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_r <= RST_VAL;
			sync_r <= RST_VAL;
			prev_r <= RST_VAL;
		end else begin
			meta_r <= i_pin;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign o_level = sync_r;
	assign o_rise  = sync_r & ~prev_r;
	assign o_fall  = ~sync_r & prev_r;
endmodule
`default_nettype wire

// ---- src/bpc_predriver_ctrl.sv ----
// pre-driver control: current chopping, brake, standby, faults, tach and lock detect
//
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module bpc_predriver_ctrl
	import bpc_pkg::*;
#(
	parameter int OFF_CYCLES     = OFF_TIME_CYCLES,
	parameter int STANDBY_CYCLES = STANDBY_TIME_CYCLES,
	parameter int LOCK_PERIODS   = LOCK_WAIT_PERIODS
)(
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// controller pins
	input  wire logic        i_drive_enable_n,
	input  wire logic        i_dir,
	input  wire logic        i_brake_request_n,
	// hall sensors
	input  wire logic        i_phase_a_hall,
	input  wire logic        i_phase_b_hall,
	input  wire logic        i_phase_c_hall,
	// commutation selection and current sense
	input  wire logic [2:0]  i_comm_hi,
	input  wire logic [2:0]  i_comm_lo,
	input  wire logic        i_current_trip,
	// analog monitors
	input  wire logic        i_pump_rail_fault,
	input  wire logic        i_motor_supply_uv,
	input  wire logic        i_supply_overvoltage,
	input  wire logic        i_temp_trip,
	input  wire logic        i_temp_release,
	// lock timer oscillator
	input  wire logic        i_lock_timer_cap_tick,
	input  wire logic        i_lock_timer_cap_grounded,
	// tach pin readback
	input  wire logic        i_hall_edge_tach,
	input  wire logic        i_phase_a_tach,
	// avalon-mm slave
	input  wire logic [3:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	// gate drives and hall supply
	output logic      [2:0]  o_gate_hi,
	output logic      [2:0]  o_gate_lo,
	output logic             o_hall_sensor_supply_en,
	// open-drain tach outputs
	output logic             o_hall_edge_tach,
	output logic             o_hall_edge_tach_oe,
	output logic             o_phase_a_tach,
	output logic             o_phase_a_tach_oe
);
	localparam int LOCK_HALF = LOCK_PERIODS / 2 + 1;

	logic [IN_W-1:0] lvl;
	logic [IN_W-1:0] rise;
	logic [IN_W-1:0] fall;
	logic [2:0]      hall;
	logic            en_off;
	logic            brake;
	logic            dir_edge;
	logic            hall_edge;
	logic            hall_a_edge;
	logic            restart;
	logic            hard_fault;
	logic            sr_ok;
	bpc_state_t      state_r;
	logic [31:0]     cnt_r;
	logic            thermal_r;
	logic [31:0]     en_high_cnt_r;
	logic            standby_r;
	logic            standby_nxt;
	logic [2:0]      hall_cur_r;
	logic [2:0]      hall_old_r;
	logic            proper_edge;
	logic            lock_active;
	logic            lock_run;
	logic [31:0]     lock_cnt_r;
	logic [31:0]     en_tick_cnt_r;
	logic            lock_set;
	logic            lock_clear;
	logic            lock_fault_r;
	logic            uv_prev_r;
	logic [31:0]     ctrl_r;
	logic [2:0]      gate_hi_nxt;
	logic [2:0]      gate_lo_nxt;
	logic            bus_req;

	// pins are retimed before any edge is taken
	bpc_input_sync #(
		.WIDTH   (IN_W),
		.RST_VAL (IN_RST_VAL)
	) i_bpc_input_sync (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_pin   ({i_brake_request_n, i_dir, i_drive_enable_n,
			i_phase_c_hall, i_phase_b_hall, i_phase_a_hall}),
		.o_level (lvl),
		.o_rise  (rise),
		.o_fall  (fall)
	);

	assign hall        = lvl[IN_HALL_C:IN_HALL_A];
	assign en_off      = lvl[IN_ENABLE_N];
	assign brake       = !lvl[IN_BRAKE_N];
	assign dir_edge    = rise[IN_DIR] | fall[IN_DIR];
	assign hall_edge   = |(rise[IN_HALL_C:IN_HALL_A] | fall[IN_HALL_C:IN_HALL_A]);
	assign hall_a_edge = rise[IN_HALL_A] | fall[IN_HALL_A];
	// blank timer held at zero while chopped, so it runs from enable-on
	assign restart     = dir_edge | en_off;
	assign hard_fault  = i_pump_rail_fault | i_motor_supply_uv | thermal_r;
	assign sr_ok       = ctrl_r[CTRL_SYNC_RECT_EN] & !i_supply_overvoltage;

	// fixed off-time chopper with blanking
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r <= BPC_BLANK;
			cnt_r   <= '0;
		end else if (restart) begin
			state_r <= BPC_BLANK;
			cnt_r   <= '0;
		end else begin
			case (state_r)
				BPC_DRIVE: begin
					if (i_current_trip) begin
						state_r <= BPC_OFF;
						cnt_r   <= '0;
					end
				end
				BPC_OFF: begin
					if (cnt_r >= 32'(OFF_CYCLES - 1)) begin
						state_r <= BPC_BLANK;
						cnt_r   <= '0;
					end else begin
						cnt_r <= cnt_r + 32'd1;
					end
				end
				BPC_BLANK: begin
					if (cnt_r >= 32'(BLANK_CYCLES - 1)) begin
						state_r <= BPC_DRIVE;
						cnt_r   <= '0;
					end else begin
						cnt_r <= cnt_r + 32'd1;
					end
				end
				default: begin
					state_r <= BPC_BLANK;
					cnt_r   <= '0;
				end
			endcase
		end
	end

	// sensor gives both thresholds; latch spans the hysteresis band
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			thermal_r <= 1'b0;
		end else if (i_temp_trip) begin
			thermal_r <= 1'b1;
		end else if (i_temp_release) begin
			thermal_r <= 1'b0;
		end
	end

	// standby timer
	always_comb begin
		standby_nxt = standby_r;
		if (!en_off || brake) begin
			standby_nxt = 1'b0;
		end else if (en_high_cnt_r >= 32'(STANDBY_CYCLES)) begin
			standby_nxt = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			en_high_cnt_r           <= '0;
			standby_r               <= 1'b0;
			o_hall_sensor_supply_en <= 1'b1;
		end else begin
			if (!en_off) begin
				en_high_cnt_r <= '0;
			end else if (en_high_cnt_r < 32'(STANDBY_CYCLES)) begin
				en_high_cnt_r <= en_high_cnt_r + 32'd1;
			end
			standby_r               <= standby_nxt;
			o_hall_sensor_supply_en <= !standby_nxt;
		end
	end

	// lock detection: bouncing back to the previous state is no progress
	assign proper_edge = hall_edge && (hall != hall_old_r)
		&& (hall != 3'b000) && (hall != 3'b111);
	assign lock_active = ctrl_r[CTRL_LOCK_EN] & !i_lock_timer_cap_grounded;
	assign lock_run    = lock_active && !brake && !en_off && !lock_fault_r;
	assign lock_set    = lock_run && i_lock_timer_cap_tick && !proper_edge
		&& (lock_cnt_r == 32'(LOCK_PERIODS - 1));
	assign lock_clear  = dir_edge || (uv_prev_r && !i_motor_supply_uv)
		|| (en_tick_cnt_r >= 32'(LOCK_HALF));

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hall_cur_r <= '0;
			hall_old_r <= '0;
		end else if (hall_edge) begin
			hall_cur_r <= hall;
			hall_old_r <= hall_cur_r;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lock_cnt_r <= '0;
		end else if (!lock_run || proper_edge) begin
			lock_cnt_r <= '0;
		end else if (i_lock_timer_cap_tick && lock_cnt_r < 32'(LOCK_PERIODS)) begin
			lock_cnt_r <= lock_cnt_r + 32'd1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			en_tick_cnt_r <= '0;
		end else if (!en_off) begin
			en_tick_cnt_r <= '0;
		end else if (i_lock_timer_cap_tick && en_tick_cnt_r < 32'(LOCK_HALF)) begin
			en_tick_cnt_r <= en_tick_cnt_r + 32'd1;
		end
	end

	// set wins over any clear in the same cycle
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lock_fault_r <= 1'b0;
			uv_prev_r    <= 1'b1;
		end else begin
			uv_prev_r <= i_motor_supply_uv;
			if (lock_set) begin
				lock_fault_r <= 1'b1;
			end else if (lock_clear || !lock_active) begin
				lock_fault_r <= 1'b0;
			end
		end
	end

	// gate selection; supply faults beat brake since no drive is safe then
	always_comb begin
		gate_hi_nxt = 3'b000;
		gate_lo_nxt = 3'b000;
		if (hard_fault) begin
			gate_hi_nxt = 3'b000;
		end else if (brake) begin
			gate_lo_nxt = 3'b111;
		end else if (lock_fault_r || standby_r) begin
			gate_hi_nxt = 3'b000;
		end else if (en_off || state_r == BPC_OFF) begin
			gate_lo_nxt = i_comm_lo | (sr_ok ? i_comm_hi : 3'b000);
		end else begin
			gate_hi_nxt = i_comm_hi;
			gate_lo_nxt = i_comm_lo;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_gate_hi <= 3'b000;
			o_gate_lo <= 3'b000;
		end else begin
			o_gate_hi <= gate_hi_nxt;
			o_gate_lo <= gate_lo_nxt;
		end
	end

	// tach: enable high means pin pulled low
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_hall_edge_tach    <= 1'b0;
			o_hall_edge_tach_oe <= 1'b0;
			o_phase_a_tach      <= 1'b0;
			o_phase_a_tach_oe   <= 1'b0;
		end else begin
			o_hall_edge_tach <= 1'b0;
			o_phase_a_tach   <= 1'b0;
			if (hall_edge) begin
				o_hall_edge_tach_oe <= !o_hall_edge_tach_oe;
			end
			if (hall_a_edge) begin
				o_phase_a_tach_oe <= !o_phase_a_tach_oe;
			end
		end
	end

	// avalon slave: one wait cycle, then a single low waitrequest
	assign bus_req = (i_avs_read | i_avs_write) & o_avs_waitrequest;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata    <= '0;
		end else begin
			o_avs_waitrequest <= !bus_req;
			if (bus_req && i_avs_read) begin
				case (i_avs_address)
					REG_CTRL:   o_avs_readdata <= ctrl_r;
					REG_STATUS: begin
						o_avs_readdata                <= '0;
						o_avs_readdata[ST_STANDBY]    <= standby_r;
						o_avs_readdata[ST_LOCK_FAULT] <= lock_fault_r;
						o_avs_readdata[ST_THERMAL]    <= thermal_r;
						o_avs_readdata[ST_BRAKE]      <= brake;
						o_avs_readdata[ST_HARD_FAULT] <= hard_fault;
						o_avs_readdata[ST_OVERVOLT]   <= i_supply_overvoltage;
						o_avs_readdata[ST_TACH1_PIN]  <= i_hall_edge_tach;
						o_avs_readdata[ST_TACH2_PIN]  <= i_phase_a_tach;
					end
					default:    o_avs_readdata <= '0;
				endcase
			end
		end
	end

	// write lands on the edge where waitrequest is seen low
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_r <= CTRL_RST;
		end else if (i_avs_write && !o_avs_waitrequest && i_avs_address == REG_CTRL
			&& i_avs_byteenable[0]) begin
			ctrl_r <= {30'h0000_0000, i_avs_writedata[CTRL_SYNC_RECT_EN:CTRL_LOCK_EN]};
		end
	end

	// checks
	sequence s_off_done;
		state_r == BPC_OFF && cnt_r >= 32'(OFF_CYCLES - 1) && !restart;
	endsequence
	sequence s_dir_flip;
		dir_edge;
	endsequence

	// blanking must last its full count, whatever the comparator says
	property p_blank_ignores_trip;
		@(posedge i_clk) disable iff (!i_rst_n)
		state_r == BPC_BLANK && cnt_r < 32'(BLANK_CYCLES - 1) && !restart
			|=> state_r == BPC_BLANK;
	endproperty
	a_blank_ignores_trip: assert property (p_blank_ignores_trip) else $error("trip in blank");

	property p_off_to_blank;
		@(posedge i_clk) disable iff (!i_rst_n)
		s_off_done |=> state_r == BPC_BLANK && cnt_r == 32'd0;
	endproperty
	a_off_to_blank: assert property (p_off_to_blank) else $error("no blank after off");

	property p_dir_restart;
		@(posedge i_clk) disable iff (!i_rst_n)
		s_dir_flip |=> state_r == BPC_BLANK ##1 (state_r == BPC_BLANK || restart);
	endproperty
	a_dir_restart: assert property (p_dir_restart) else $error("dir did not blank");

	property p_trip_off;
		@(posedge i_clk) disable iff (!i_rst_n)
		state_r == BPC_DRIVE && i_current_trip && !restart |=> state_r == BPC_OFF;
	endproperty
	a_trip_off: assert property (p_trip_off) else $error("trip ignored");

	property p_brake_low;
		@(posedge i_clk) disable iff (!i_rst_n)
		brake && !hard_fault |=> o_gate_lo == 3'b111 && o_gate_hi == 3'b000;
	endproperty
	a_brake_low: assert property (p_brake_low) else $error("brake gates wrong");

	property p_pump_off;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_pump_rail_fault |=> o_gate_hi == 3'b000 && o_gate_lo == 3'b000;
	endproperty
	a_pump_off: assert property (p_pump_off) else $error("gates on in pump fault");

	property p_ov_no_sr;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_supply_overvoltage && !brake |=> (o_gate_lo & ~$past(i_comm_lo)) == 3'b000;
	endproperty
	a_ov_no_sr: assert property (p_ov_no_sr) else $error("sync rect in overvoltage");

	property p_tach1;
		@(posedge i_clk) disable iff (!i_rst_n)
		hall_edge |=> o_hall_edge_tach_oe != $past(o_hall_edge_tach_oe);
	endproperty
	a_tach1: assert property (p_tach1) else $error("tach1 missed edge");

	property p_tach2;
		@(posedge i_clk) disable iff (!i_rst_n)
		!hall_a_edge |=> o_phase_a_tach_oe == $past(o_phase_a_tach_oe);
	endproperty
	a_tach2: assert property (p_tach2) else $error("tach2 moved");

	property p_lock_latch;
		@(posedge i_clk) disable iff (!i_rst_n)
		lock_set |=> lock_fault_r ##1 (o_gate_hi == 3'b000);
	endproperty
	a_lock_latch: assert property (p_lock_latch) else $error("lock not latched");

	property p_brake_lock_hold;
		@(posedge i_clk) disable iff (!i_rst_n)
		brake |=> lock_cnt_r == 32'd0;
	endproperty
	a_brake_lock_hold: assert property (p_brake_lock_hold) else $error("lock ran in brake");

	property p_standby;
		@(posedge i_clk) disable iff (!i_rst_n)
		standby_r |-> !o_hall_sensor_supply_en && $past(en_off) && !$past(brake);
	endproperty
	a_standby: assert property (p_standby) else $error("standby wrong");

	property p_standby_entry;
		@(posedge i_clk) disable iff (!i_rst_n)
		en_off && !brake && en_high_cnt_r >= 32'(STANDBY_CYCLES) |=> standby_r;
	endproperty
	a_standby_entry: assert property (p_standby_entry) else $error("standby not entered");
endmodule
`default_nettype wire

// ---- tb/bpc_hall_osc_model.sv ----
// hall sensor and lock timer oscillator model facing the pre-driver block
`timescale 1ns/10ps
`default_nettype none
module bpc_hall_osc_model #(
	parameter int TICK_DIV = 10
)(
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	// commands from the bench
	input  wire logic i_spin,
	input  wire logic i_step,
	input  wire logic i_tick_en,
	// hall levels and oscillator tick
	output logic      o_hall_a,
	output logic      o_hall_b,
	output logic      o_hall_c,
	output logic      o_tick
);
	// forward commutation order, a/b/c
	localparam logic [2:0] SEQ [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
	logic [2:0] idx_r;
	logic [4:0] spin_r;
	logic [7:0] tick_r;
	assign {o_hall_a, o_hall_b, o_hall_c} = SEQ[idx_r];
	// spinning steps every 20 cycles, the length of two ticks, so edges always reset the lock count
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			idx_r  <= 3'h0;
			spin_r <= 5'h00;
		end else begin
			spin_r <= (spin_r == 5'h13) ? 5'h00 : spin_r + 5'h01;
			if (i_step || (i_spin && spin_r == 5'h13)) begin
				idx_r <= (idx_r == 3'h5) ? 3'h0 : idx_r + 3'h1;
			end
		end
	end
	// tick period stands in for one triangle period
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tick_r <= 8'h00;
			o_tick <= 1'b0;
		end else if (!i_tick_en) begin
			tick_r <= 8'h00;
			o_tick <= 1'b0;
		end else begin
			o_tick <= (tick_r == 8'(TICK_DIV - 1));
			tick_r <= (tick_r == 8'(TICK_DIV - 1)) ? 8'h00 : tick_r + 8'h01;
		end
	end
endmodule
`default_nettype wire

// ---- tb/bpc_predriver_ctrl_tb.sv ----
// self-checking bench for the motor pre-driver control block
`timescale 1ns/10ps
`default_nettype none
module bpc_predriver_ctrl_tb;
	import bpc_pkg::*;
	logic        clk = 1'b0, rst_n = 1'b0;
	logic        en_n = 1'b1, dir = 1'b0, brk_n = 1'b1, trip = 1'b0;
	logic        pump = 1'b0, uv = 1'b0, ov = 1'b0, t_trip = 1'b0, t_rel = 1'b1;
	logic        gnd_cap = 1'b0, spin = 1'b0, step = 1'b0, tick_en = 1'b0;
	logic        ha, hb, hc, tick, t1_pin, t2_pin, o1, o2;
	logic [2:0]  c_hi = 3'h1, c_lo = 3'h2, g_hi, g_lo;
	logic [3:0]  addr = 4'h0;
	logic        rd = 1'b0, wr = 1'b0, wreq, hsup, t1, t1_oe, t2, t2_oe;
	logic [31:0] wdat = 32'h0000_0000, rdat, d;
	int          fails = 0, checks = 0;

	always #2.5 clk = ~clk;
	// open-drain tach pins with pull-ups
	assign t1_pin = t1_oe ? t1 : 1'b1;
	assign t2_pin = t2_oe ? t2 : 1'b1;

	bpc_predriver_ctrl #(.OFF_CYCLES(50), .STANDBY_CYCLES(200), .LOCK_PERIODS(7))
	i_bpc_predriver_ctrl (
		.i_clk(clk), .i_rst_n(rst_n), .i_drive_enable_n(en_n), .i_dir(dir),
		.i_brake_request_n(brk_n), .i_phase_a_hall(ha), .i_phase_b_hall(hb),
		.i_phase_c_hall(hc), .i_comm_hi(c_hi), .i_comm_lo(c_lo), .i_current_trip(trip),
		.i_pump_rail_fault(pump), .i_motor_supply_uv(uv), .i_supply_overvoltage(ov),
		.i_temp_trip(t_trip), .i_temp_release(t_rel), .i_lock_timer_cap_tick(tick),
		.i_lock_timer_cap_grounded(gnd_cap), .i_hall_edge_tach(t1_pin),
		.i_phase_a_tach(t2_pin), .i_avs_address(addr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hf),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_gate_hi(g_hi),
		.o_gate_lo(g_lo), .o_hall_sensor_supply_en(hsup), .o_hall_edge_tach(t1),
		.o_hall_edge_tach_oe(t1_oe), .o_phase_a_tach(t2), .o_phase_a_tach_oe(t2_oe));

	bpc_hall_osc_model #(.TICK_DIV(10)) i_bpc_hall_osc_model (
		.i_clk(clk), .i_rst_n(rst_n), .i_spin(spin), .i_step(step), .i_tick_en(tick_en),
		.o_hall_a(ha), .o_hall_b(hb), .o_hall_c(hc), .o_tick(tick));

	task automatic print_verdict();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// one avalon transfer; held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		addr <= a;
		wr <= w;
		rd <= !w;
		wdat <= wd;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 20);
		chk("waitrequest", 32'(wreq), 32'h0);
		d = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic st(input int b, input logic e);
		bus(1'b0, REG_STATUS, 32'h0000_0000);
		chk("status", 32'(d[b]), 32'(e));
	endtask

	task automatic gates(input logic [2:0] h, input logic [2:0] l);
		chk("gate_hi", 32'(g_hi), 32'(h));
		chk("gate_lo", 32'(g_lo), 32'(l));
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		print_verdict();
	end

	initial begin
		cyc(20);
		rst_n <= 1'b1;
		cyc(1);
		gates(3'h0, 3'h0);
		chk("reset", 32'({hsup, t2_oe, t1_oe, wreq}), 32'h9);
		bus(1'b0, REG_CTRL, 32'h0000_0000);
		chk("ctrl", d, CTRL_RST);
		bus(1'b1, 4'h8, 32'h0000_0000);
		bus(1'b0, 4'h8, 32'h0000_0000);
		chk("unmapped", d, 32'h0000_0000);
		bus(1'b0, REG_CTRL, 32'h0000_0000);
		chk("ctrl", d, CTRL_RST);
		// hall steps c, b, then a
		for (int k = 0; k < 3; k++) begin
			o1 = t1_oe;
			o2 = t2_oe;
			step <= 1'b1;
			cyc(1);
			step <= 1'b0;
			cyc(6);
			chk("tach1", 32'(t1_oe), 32'(!o1));
			chk("tach2", 32'(t2_oe), 32'(k == 2 ? !o2 : o2));
		end
		chk("tach_data", 32'({t1, t2}), 32'h0);
		bus(1'b0, REG_STATUS, 32'h0000_0000);
		chk("tach_pins", 32'(d[ST_TACH2_PIN:ST_TACH1_PIN]), 32'({!t2_oe, !t1_oe}));
		// chopping: blank, trip, off-time, blank again
		en_n <= 1'b0;
		cyc(10);
		gates(3'h1, 3'h2);
		trip <= 1'b1;
		cyc(100);
		gates(3'h1, 3'h2);
		cyc(210);
		gates(3'h0, 3'h3);
		trip <= 1'b0;
		cyc(20);
		gates(3'h0, 3'h3);
		cyc(100);
		trip <= 1'b1;
		cyc(100);
		gates(3'h1, 3'h2);
		trip <= 1'b0;
		cyc(200);
		ov <= 1'b1;
		trip <= 1'b1;
		cyc(5);
		gates(3'h0, 3'h2);
		st(ST_OVERVOLT, 1'b1);
		ov <= 1'b0;
		trip <= 1'b0;
		cyc(400);
		bus(1'b1, REG_CTRL, 32'h0000_0001);
		trip <= 1'b1;
		cyc(5);
		gates(3'h0, 3'h2);
		trip <= 1'b0;
		bus(1'b1, REG_CTRL, CTRL_RST);
		cyc(400);
		// enable chop, then direction change
		en_n <= 1'b1;
		cyc(6);
		gates(3'h0, 3'h3);
		en_n <= 1'b0;
		cyc(10);
		trip <= 1'b1;
		cyc(20);
		gates(3'h1, 3'h2);
		trip <= 1'b0;
		cyc(300);
		dir <= 1'b1;
		cyc(10);
		trip <= 1'b1;
		cyc(20);
		gates(3'h1, 3'h2);
		trip <= 1'b0;
		cyc(300);
		// brake wins over enable and standby
		brk_n <= 1'b0;
		cyc(6);
		gates(3'h0, 3'h7);
		st(ST_BRAKE, 1'b1);
		en_n <= 1'b1;
		cyc(250);
		chk("hall_supply", 32'(hsup), 32'h1);
		gates(3'h0, 3'h7);
		brk_n <= 1'b1;
		en_n <= 1'b0;
		cyc(10);
		en_n <= 1'b1;
		cyc(150);
		chk("hall_supply", 32'(hsup), 32'h1);
		cyc(60);
		chk("hall_supply", 32'(hsup), 32'h0);
		gates(3'h0, 3'h0);
		st(ST_STANDBY, 1'b1);
		en_n <= 1'b0;
		cyc(310);
		chk("hall_supply", 32'(hsup), 32'h1);
		// hard faults
		pump <= 1'b1;
		cyc(5);
		gates(3'h0, 3'h0);
		st(ST_HARD_FAULT, 1'b1);
		pump <= 1'b0;
		uv <= 1'b1;
		cyc(5);
		gates(3'h0, 3'h0);
		uv <= 1'b0;
		cyc(5);
		gates(3'h1, 3'h2);
		t_rel <= 1'b0;
		t_trip <= 1'b1;
		cyc(5);
		gates(3'h0, 3'h0);
		t_trip <= 1'b0;
		cyc(5);
		gates(3'h0, 3'h0);
		st(ST_THERMAL, 1'b1);
		t_rel <= 1'b1;
		cyc(5);
		gates(3'h1, 3'h2);
		// stalled rotor; ticks also run where the count must hold, in brake and with the capacitor grounded
		tick_en <= 1'b1;
		cyc(65);
		gates(3'h1, 3'h2);
		cyc(15);
		gates(3'h0, 3'h0);
		st(ST_LOCK_FAULT, 1'b1);
		dir <= 1'b0;
		tick_en <= 1'b0;
		cyc(6);
		st(ST_LOCK_FAULT, 1'b0);
		cyc(310);
		brk_n <= 1'b0;
		tick_en <= 1'b1;
		cyc(100);
		brk_n <= 1'b1;
		cyc(30);
		st(ST_LOCK_FAULT, 1'b0);
		cyc(80);
		st(ST_LOCK_FAULT, 1'b1);
		en_n <= 1'b1;
		cyc(25);
		st(ST_LOCK_FAULT, 1'b1);
		cyc(90);
		st(ST_LOCK_FAULT, 1'b0);
		en_n <= 1'b0;
		tick_en <= 1'b0;
		cyc(310);
		gnd_cap <= 1'b1;
		tick_en <= 1'b1;
		cyc(150);
		st(ST_LOCK_FAULT, 1'b0);
		gates(3'h1, 3'h2);
		gnd_cap <= 1'b0;
		// lock detect switched off by software, ticks still running
		bus(1'b1, REG_CTRL, 32'h0000_0002);
		cyc(100);
		st(ST_LOCK_FAULT, 1'b0);
		gates(3'h1, 3'h2);
		bus(1'b1, REG_CTRL, CTRL_RST);
		spin <= 1'b1;
		cyc(150);
		st(ST_LOCK_FAULT, 1'b0);
		print_verdict();
	end
endmodule
`default_nettype wire
